// ### verilog/bod_pkg.sv
// Constants and types for the byte-operation decode and execute block
package bod_pkg;
    // Register bus offsets
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_STATE   = 8'h04;
    localparam logic [7:0]  REG_INDEX   = 8'h08;
    localparam logic [7:0]  REG_BANK    = 8'h0C;
    localparam logic [7:0]  REG_PROD    = 8'h10;
    // Control fields, reset value and bus answers
    localparam int          CTRL_EXT    = 0;
    localparam int          CTRL_PSA    = 1;
    localparam logic [1:0]  CTRL_RST    = 2'h0;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // File map
    localparam logic [11:0] PORT_ADDR   = 12'hF80;
    localparam logic [11:0] TIMER_ADDR  = 12'hF90;
    localparam logic [7:0]  ACC_LIMIT   = 8'h5F;
    localparam logic [3:0]  ACC_HIGH    = 4'hF;
    // Whole-word and prefix encodings
    localparam logic [15:0] DECIMAL_ADJUST_WORD = 16'h0007;
    localparam logic [3:0]  MOVE_FIRST  = 4'hC;
    localparam logic [3:0]  MOVE_SECOND = 4'hF;
    // Six-bit opcodes of operations with a destination bit
    localparam logic [5:0]  ADD_WORKING_OP             = 6'h09;
    localparam logic [5:0]  ADD_WITH_CARRY_OP          = 6'h08;
    localparam logic [5:0]  INCREMENT_FILE_OP          = 6'h0A;
    localparam logic [5:0]  DECREMENT_FILE_OP          = 6'h01;
    localparam logic [5:0]  SUBTRACT_WORKING_OP        = 6'h17;
    localparam logic [5:0]  SUBTRACT_WORKING_BORROW_OP = 6'h16;
    localparam logic [5:0]  REVERSE_SUBTRACT_BORROW_OP = 6'h15;
    localparam logic [5:0]  AND_WORKING_OP             = 6'h05;
    localparam logic [5:0]  INCLUSIVE_OR_OP            = 6'h04;
    localparam logic [5:0]  EXCLUSIVE_OR_OP            = 6'h06;
    localparam logic [5:0]  COMPLEMENT_OP              = 6'h07;
    localparam logic [5:0]  ROTATE_LEFT_CARRY_OP       = 6'h0D;
    localparam logic [5:0]  ROTATE_RIGHT_CARRY_OP      = 6'h0C;
    localparam logic [5:0]  ROTATE_LEFT_PLAIN_OP       = 6'h11;
    localparam logic [5:0]  ROTATE_RIGHT_PLAIN_OP      = 6'h10;
    localparam logic [5:0]  DECREMENT_SKIP_ZERO_OP     = 6'h0B;
    localparam logic [5:0]  DECREMENT_SKIP_NONZERO_OP  = 6'h13;
    localparam logic [5:0]  INCREMENT_SKIP_ZERO_OP     = 6'h0F;
    localparam logic [5:0]  INCREMENT_SKIP_NONZERO_OP  = 6'h12;
    // Seven-bit opcodes of operations without a destination bit
    localparam logic [6:0]  COMPARE_SKIP_EQUAL_OP      = 7'h31;
    localparam logic [6:0]  COMPARE_SKIP_GREATER_OP    = 7'h32;
    localparam logic [6:0]  COMPARE_SKIP_LESS_OP       = 7'h30;
    localparam logic [6:0]  TEST_SKIP_ZERO_OP          = 7'h33;
    localparam logic [6:0]  MULTIPLY_WORKING_OP        = 7'h01;
    // Status flags
    typedef struct packed {
        logic neg;
        logic sign_wrap;
        logic zero;
        logic half_carry;
        logic carry;
    } bod_flags_s;
    localparam bod_flags_s FLAGS_RST = 5'h00;
    // Four internal phases of one instruction cycle
    typedef enum logic [1:0] {
        PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE
    } bod_phase_e;
endpackage

// ### verilog/bod_core.sv
// Byte-operation decode and execute core with an AXI4-Lite register slave
//
// Notes on behaviour
// - Destination bit 0 writes the working register, 1 writes the file.
// - Access bit 0 uses the access bank; 1 uses the bank select register.
// - Extended set, access bit 0, address up to 95: indexed offset.
// - Decrement file subtracts one and updates all five arithmetic flags.
// - Decimal adjust adds six per nibble above nine or with carry.
// - A true skip test makes the next word run as a no-operation.
// - An orphan second word of a two-word op runs as a no-operation.
// - File-to-file move takes two words, two cycles, flags untouched.
// - Reading the port register returns pin levels, not the latch.
// - Qualifying ops on the timer count clear an assigned prescaler.
// - Compare and test ops skip on their condition; flags untouched.
// - Decrement and increment skip ops store the value; flags untouched.
// - Add and add with carry update all five arithmetic flags.
// - The three subtract forms update all five arithmetic flags.
// - And, or, exclusive or and complement update zero and negative.
// - Carry rotates update carry, zero, negative; plain ones zero, neg.
// - Multiply takes one cycle and leaves every flag unchanged.
`timescale 1ns/1ps
module bod_core #(
    parameter int PRESC_W = 8
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic [15:0] instr_word,
    input  wire logic        instr_valid,
    output logic             instr_ready,
    input  wire logic [7:0]  port_pins,
    output logic [7:0]       port_out
);
    bod_pkg::bod_phase_e ph_q;
    bod_pkg::bod_flags_s flg_q, flg_d;
    logic [15:0]  ir_q, prod_q;
    logic [7:0]   working_register_q, opnd_q, mv_data_q;
    logic [7:0]   timer_zero_count_q, pin_s1, pin_s2, pin_s3, pin_q;
    logic [11:0]  index_q, ea;
    logic [3:0]   bank_select_register_q;
    logic [1:0]   ctrl_q;
    logic [PRESC_W-1:0] presc_q;
    logic         nop_q, skip_q, mv2_q, mvsec_q, take, exec;
    logic         aw_ok_q, w_ok_q, wr_go;
    logic [7:0]   awaddr_q;
    logic [31:0]  wdata_q;
    logic [3:0]   wstrb_q;
    logic [7:0]   mem [0:4095];
    logic [5:0]   op6;
    logic [6:0]   op7;
    logic [7:0]   f8, res, aa, bb, rd_val;
    logic         d_bit, a_bit, first_mv, has_d, skip_c, is_cmp, is_mul;
    logic         is_daw, arith, zn, cin, file_we, w_we, tmr_clr;
    logic [8:0]   sum, daw_t, daw_u;
    logic [4:0]   nib;

    // Instruction field split
    assign op6      = ir_q[15:10];
    assign op7      = ir_q[15:9];
    assign d_bit    = ir_q[9];
    assign a_bit    = ir_q[8];
    assign f8       = ir_q[7:0];
    assign first_mv = ir_q[15:12] == bod_pkg::MOVE_FIRST;
    assign is_daw   = ir_q == bod_pkg::DECIMAL_ADJUST_WORD;
    assign is_mul   = op7 == bod_pkg::MULTIPLY_WORKING_OP;
    assign is_cmp   = op7[6:2] == bod_pkg::COMPARE_SKIP_LESS_OP[6:2];
    assign instr_ready = ph_q == bod_pkg::PH_DECODE;
    assign take     = instr_valid && instr_ready;
    assign exec     = ph_q == bod_pkg::PH_WRITE && !nop_q;

    // Pin synchroniser; a bit changes once stages two and three agree
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_s1 <= 8'h00;
            pin_s2 <= 8'h00;
            pin_s3 <= 8'h00;
            pin_q  <= 8'h00;
        end
        else
        begin
            pin_s1 <= port_pins;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_q  <= (pin_s2 & pin_s3) | (pin_q & (pin_s2 ^ pin_s3));
        end
    end

    // Effective file address
    always_comb
    begin
        if (first_mv || mvsec_q)
            ea = ir_q[11:0];
        else if (a_bit)
            ea = {bank_select_register_q, f8};
        else if (ctrl_q[bod_pkg::CTRL_EXT] && f8 <= bod_pkg::ACC_LIMIT)
            ea = index_q + {4'h0, f8};
        else if (f8 <= bod_pkg::ACC_LIMIT)
            ea = {4'h0, f8};
        else
            ea = {bod_pkg::ACC_HIGH, f8};
    end

    assign rd_val = ea == bod_pkg::PORT_ADDR ? pin_q :
                    ea == bod_pkg::TIMER_ADDR ? timer_zero_count_q : mem[ea];

    // Arithmetic and logic on the fetched operand
    always_comb
    begin
        aa = opnd_q;
        bb = 8'h00;
        cin = 1'b0;
        res = opnd_q;
        flg_d = flg_q;
        arith = 1'b0;
        zn = 1'b0;
        has_d = 1'b1;
        skip_c = 1'b0;
        unique case (op6)
            bod_pkg::ADD_WORKING_OP:
            begin
                bb = working_register_q;
                arith = 1'b1;
            end
            bod_pkg::ADD_WITH_CARRY_OP:
            begin
                bb = working_register_q;
                cin = flg_q.carry;
                arith = 1'b1;
            end
            bod_pkg::INCREMENT_FILE_OP:
            begin
                bb = 8'h01;
                arith = 1'b1;
            end
            bod_pkg::DECREMENT_FILE_OP:
            begin
                bb = 8'hFF;
                arith = 1'b1;
            end
            bod_pkg::SUBTRACT_WORKING_OP:
            begin
                bb = ~working_register_q;
                cin = 1'b1;
                arith = 1'b1;
            end
            bod_pkg::SUBTRACT_WORKING_BORROW_OP:
            begin
                bb = ~working_register_q;
                cin = flg_q.carry;
                arith = 1'b1;
            end
            bod_pkg::REVERSE_SUBTRACT_BORROW_OP:
            begin
                aa = working_register_q;
                bb = ~opnd_q;
                cin = flg_q.carry;
                arith = 1'b1;
            end
            bod_pkg::AND_WORKING_OP:
            begin
                res = opnd_q & working_register_q;
                zn = 1'b1;
            end
            bod_pkg::INCLUSIVE_OR_OP:
            begin
                res = opnd_q | working_register_q;
                zn = 1'b1;
            end
            bod_pkg::EXCLUSIVE_OR_OP:
            begin
                res = opnd_q ^ working_register_q;
                zn = 1'b1;
            end
            bod_pkg::COMPLEMENT_OP:
            begin
                res = ~opnd_q;
                zn = 1'b1;
            end
            bod_pkg::ROTATE_LEFT_CARRY_OP:
            begin
                res = {opnd_q[6:0], flg_q.carry};
                flg_d.carry = opnd_q[7];
                zn = 1'b1;
            end
            bod_pkg::ROTATE_RIGHT_CARRY_OP:
            begin
                res = {flg_q.carry, opnd_q[7:1]};
                flg_d.carry = opnd_q[0];
                zn = 1'b1;
            end
            bod_pkg::ROTATE_LEFT_PLAIN_OP:
            begin
                res = {opnd_q[6:0], opnd_q[7]};
                zn = 1'b1;
            end
            bod_pkg::ROTATE_RIGHT_PLAIN_OP:
            begin
                res = {opnd_q[0], opnd_q[7:1]};
                zn = 1'b1;
            end
            bod_pkg::DECREMENT_SKIP_ZERO_OP:
            begin
                res = opnd_q - 8'h01;
                skip_c = res == 8'h00;
            end
            bod_pkg::DECREMENT_SKIP_NONZERO_OP:
            begin
                res = opnd_q - 8'h01;
                skip_c = res != 8'h00;
            end
            bod_pkg::INCREMENT_SKIP_ZERO_OP:
            begin
                res = opnd_q + 8'h01;
                skip_c = res == 8'h00;
            end
            bod_pkg::INCREMENT_SKIP_NONZERO_OP:
            begin
                res = opnd_q + 8'h01;
                skip_c = res != 8'h00;
            end
            default:
                has_d = 1'b0;
        endcase
        if (op7 == bod_pkg::COMPARE_SKIP_EQUAL_OP)
            skip_c = opnd_q == working_register_q;
        if (op7 == bod_pkg::COMPARE_SKIP_GREATER_OP)
            skip_c = opnd_q > working_register_q;
        if (op7 == bod_pkg::COMPARE_SKIP_LESS_OP)
            skip_c = opnd_q < working_register_q;
        if (op7 == bod_pkg::TEST_SKIP_ZERO_OP)
            skip_c = opnd_q == 8'h00;
        sum = {1'b0, aa} + {1'b0, bb} + {8'h00, cin};
        nib = {1'b0, aa[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
        if (arith)
        begin
            res = sum[7:0];
            flg_d.carry = sum[8];
            flg_d.half_carry = nib[4];
            flg_d.sign_wrap = (aa[7] == bb[7]) && (sum[7] != aa[7]);
            zn = 1'b1;
        end
        if (zn)
        begin
            flg_d.zero = res == 8'h00;
            flg_d.neg = res[7];
        end
        daw_t = {1'b0, working_register_q} +
                ((working_register_q[3:0] > 4'h9 || flg_q.half_carry) ?
                 9'h006 : 9'h000);
        daw_u = daw_t + ((daw_t[7:4] > 4'h9 || flg_q.carry || daw_t[8]) ?
                         9'h060 : 9'h000);
        if (is_daw)
        begin
            res = daw_u[7:0];
            flg_d.carry = flg_q.carry | daw_t[8] | daw_u[8];
        end
    end

    assign file_we = exec && ((has_d && d_bit) || mvsec_q);
    assign w_we    = exec && ((has_d && !d_bit) || is_daw);
    assign tmr_clr = exec && ctrl_q[bod_pkg::CTRL_PSA] &&
                     ea == bod_pkg::TIMER_ADDR &&
                     (has_d ? d_bit : (is_cmp || is_mul));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ph_q    <= bod_pkg::PH_DECODE;
            ir_q    <= 16'h0000;
            nop_q   <= 1'b1;
            skip_q  <= 1'b0;
            mv2_q   <= 1'b0;
            mvsec_q <= 1'b0;
        end
        else
        begin
            unique case (ph_q)
                bod_pkg::PH_DECODE:
                    if (take)
                    begin
                        ph_q    <= bod_pkg::PH_READ;
                        ir_q    <= instr_word;
                        nop_q   <= skip_q || (!mv2_q &&
                                   instr_word[15:12] == bod_pkg::MOVE_SECOND);
                        mvsec_q <= mv2_q;
                        mv2_q   <= 1'b0;
                        skip_q  <= 1'b0;
                    end
                bod_pkg::PH_READ:    ph_q <= bod_pkg::PH_PROCESS;
                bod_pkg::PH_PROCESS: ph_q <= bod_pkg::PH_WRITE;
                bod_pkg::PH_WRITE:
                begin
                    ph_q <= bod_pkg::PH_DECODE;
                    skip_q <= exec && skip_c;
                    mv2_q  <= exec && first_mv;
                end
            endcase
        end
    end

    // Operand read, move buffer, working register, flags and product
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            opnd_q <= 8'h00;
            mv_data_q <= 8'h00;
            working_register_q <= 8'h00;
            flg_q <= bod_pkg::FLAGS_RST;
            prod_q <= 16'h0000;
        end
        else
        begin
            if (ph_q == bod_pkg::PH_READ)
                opnd_q <= rd_val;
            if (exec && first_mv)
                mv_data_q <= opnd_q;
            if (w_we)
                working_register_q <= res;
            if (exec && !first_mv && !mvsec_q)
                flg_q <= flg_d;
            if (exec && is_mul)
                prod_q <= {8'h00, opnd_q} * {8'h00, working_register_q};
        end
    end

    // File memory write
    always_ff @(posedge aclk)
    begin
        if (file_we)
            mem[ea] <= mvsec_q ? mv_data_q : res;
    end

    // Port latch, timer count and prescaler
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port_out <= 8'h00;
            timer_zero_count_q <= 8'h00;
            presc_q <= '0;
        end
        else
        begin
            if (file_we && ea == bod_pkg::PORT_ADDR)
                port_out <= mvsec_q ? mv_data_q : res;
            presc_q <= tmr_clr ? '0 : presc_q + PRESC_W'(1);
            if (file_we && ea == bod_pkg::TIMER_ADDR)
                timer_zero_count_q <= mvsec_q ? mv_data_q : res;
            else if (!ctrl_q[bod_pkg::CTRL_PSA] || &presc_q)
                timer_zero_count_q <= timer_zero_count_q + 8'h01;
        end
    end

    // Bus write channels, taken in either order
    assign awready = !aw_ok_q && !bvalid;
    assign wready  = !w_ok_q && !bvalid;
    assign wr_go   = aw_ok_q && w_ok_q && !bvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_ok_q <= 1'b0;
            w_ok_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= bod_pkg::RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_ok_q <= 1'b1;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_ok_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (wr_go)
            begin
                aw_ok_q <= 1'b0;
                w_ok_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (awaddr_q == bod_pkg::REG_CTRL ||
                          awaddr_q == bod_pkg::REG_INDEX ||
                          awaddr_q == bod_pkg::REG_BANK) ?
                         bod_pkg::RESP_OKAY : bod_pkg::RESP_SLVERR;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    // Software-writable control, index base and bank
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q <= bod_pkg::CTRL_RST;
            index_q <= 12'h000;
            bank_select_register_q <= 4'h0;
        end
        else if (wr_go)
        begin
            if (awaddr_q == bod_pkg::REG_CTRL && wstrb_q[0])
                ctrl_q <= wdata_q[1:0];
            if (awaddr_q == bod_pkg::REG_INDEX && wstrb_q[0])
                index_q[7:0] <= wdata_q[7:0];
            if (awaddr_q == bod_pkg::REG_INDEX && wstrb_q[1])
                index_q[11:8] <= wdata_q[11:8];
            if (awaddr_q == bod_pkg::REG_BANK && wstrb_q[0])
                bank_select_register_q <= wdata_q[3:0];
        end
    end

    // Bus read channel, one word per request
    assign arready = !rvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= bod_pkg::RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rresp <= bod_pkg::RESP_OKAY;
            unique case (araddr)
                bod_pkg::REG_CTRL:  rdata <= {30'h0, ctrl_q};
                bod_pkg::REG_STATE: rdata <= {port_out, timer_zero_count_q,
                                              3'h0, flg_q, working_register_q};
                bod_pkg::REG_INDEX: rdata <= {20'h0, index_q};
                bod_pkg::REG_BANK:  rdata <= {28'h0, bank_select_register_q};
                bod_pkg::REG_PROD:  rdata <= {16'h0, prod_q};
                default:
                begin
                    rdata <= 32'h0000_0000;
                    rresp <= bod_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (rready)
            rvalid <= 1'b0;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    dest_working_a: assert property (w_we |=> working_register_q == $past(res))
        else $error("working register not loaded");
    bank_addr_a: assert property (ph_q == bod_pkg::PH_READ && a_bit &&
        !first_mv && !mvsec_q |-> ea == {bank_select_register_q, f8})
        else $error("bank address wrong");
    index_addr_a: assert property (ph_q == bod_pkg::PH_READ && !a_bit &&
        ctrl_q[0] && f8 <= 8'h5F && !first_mv && !mvsec_q
        |-> ea == index_q + {4'h0, f8})
        else $error("indexed address wrong");
    skip_arm_a: assert property (exec && skip_c |=> skip_q)
        else $error("skip not armed");
    skip_nop_a: assert property (take && skip_q |-> ##3
        !exec && !file_we && !w_we)
        else $error("skipped word executed");
    orphan_nop_a: assert property (take && !mv2_q &&
        instr_word[15:12] == 4'hF |=> nop_q)
        else $error("orphan word executed");
    flags_kept_a: assert property (exec && (first_mv || mvsec_q ||
        is_cmp || is_mul || skip_c) |=> $stable(flg_q))
        else $error("flags changed");
    pin_read_a: assert property (ph_q == bod_pkg::PH_READ &&
        ea == bod_pkg::PORT_ADDR |=> opnd_q == $past(pin_q))
        else $error("port read latch");
    presc_clear_a: assert property (tmr_clr |=> presc_q == '0)
        else $error("prescaler kept");
    phase_walk_a: assert property (ph_q == bod_pkg::PH_READ |=>
        ph_q == bod_pkg::PH_PROCESS ##1 ph_q == bod_pkg::PH_WRITE
        ##1 ph_q == bod_pkg::PH_DECODE)
        else $error("phase order broken");
    cover_skip_c: cover property (exec && skip_c);
    cover_move_c: cover property (file_we && mvsec_q);
    cover_adjust_c: cover property (exec && is_daw && daw_u[8]);
    cover_index_c: cover property (exec && ctrl_q[0] && !a_bit);
endmodule

// ### verif/bod_prog_mem.sv
// Program memory model that hands instruction words to the core
`timescale 1ns/1ps
module bod_prog_mem (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        instr_ready,
    output logic [15:0]      instr_word,
    output logic             instr_valid
);
    logic [15:0] mem [0:15];
    logic [4:0]  cnt = 5'h00;
    logic [3:0]  ptr;
    // Step to the next word on each take
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ptr <= 4'h0;
        else if (instr_valid && instr_ready)
            ptr <= ptr + 4'h1;
    end
    // Past the last word the bus shows the inverse, never a stale copy
    assign instr_valid = {1'b0, ptr} < cnt;
    assign instr_word  = instr_valid ? mem[ptr] : ~mem[ptr - 4'h1];
endmodule

// ### verif/byte_op_instruction_decoder_test.sv
// Self-checking bench for the byte-operation decode and execute core
`timescale 1ns/1ps
module byte_op_instruction_decoder_test;
    localparam logic [31:0] M = 32'hFF001FFF; // Timer field masked
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, instr_ready;
    logic        instr_valid;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, port_pins = 8'h3C;
    logic [7:0]  port_out;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp, r;
    logic [15:0] instr_word;
    int          err_total = 0, samples_checked = 0, cyc = 0;
    bod_core uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .instr_word,
        .instr_valid, .instr_ready, .port_pins, .port_out);
    bod_prog_mem pm (.aclk, .aresetn, .instr_ready, .instr_word,
        .instr_valid);
    // Clock and hang guard
    always #25 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            finish_test();
        end
    end
    // Compare and count
    task automatic chk(input string n, input logic [31:0] g, e);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // Register write; ready sampled before the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic qa, qw, bv;
        bv = 1'b0;
        @(posedge aclk);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!bv)
        begin
            @(negedge aclk);
            qa = awready; qw = wready; bv = bvalid; r = bresp;
            @(posedge aclk);
            if (qa) awvalid <= 0;
            if (qw) wvalid <= 0;
        end
        bready <= 0;
    endtask
    // Register read
    task automatic rd(input logic [7:0] a);
        logic q, rv;
        rv = 1'b0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        while (!rv)
        begin
            @(negedge aclk);
            q = arready; rv = rvalid; d = rdata; r = rresp;
            @(posedge aclk);
            if (q) arvalid <= 0;
        end
        rready <= 0;
    endtask
    // Append words to program memory; four cycles per word
    task automatic run(input logic [15:0] w[$]);
        @(posedge aclk);
        foreach (w[i]) pm.mem[int'(pm.cnt) + i] = w[i];
        pm.cnt <= pm.cnt + 5'(w.size());
        repeat (4 * w.size() + 6) @(posedge aclk);
    endtask
    // Reset values, read-back, refused accesses
    task automatic t_regs();
        rd(bod_pkg::REG_STATE);
        chk("state rst", d & M, 32'h0);
        wr(bod_pkg::REG_CTRL, 32'h3);
        rd(bod_pkg::REG_CTRL);
        chk("ctrl", d, 32'h3);
        rd(8'h40);
        chk("bad read", {d[31:2], r}, {30'h0, bod_pkg::RESP_SLVERR});
        wr(bod_pkg::REG_STATE, 32'h1);
        chk("ro write", {30'h0, r}, {30'h0, bod_pkg::RESP_SLVERR});
        wr(bod_pkg::REG_CTRL, 32'h0);
        $display("register test done");
    endtask
    // Add from pins, decrement into port, decimal adjust
    task automatic t_arith();
        run('{16'h2480, 16'h0680, 16'h0007});
        rd(bod_pkg::REG_STATE);
        chk("arith", d & M, 32'h3B0003A2);
        $display("arithmetic test done");
    endtask
    // Taken skip, then an orphan second word
    task automatic t_skip();
        run('{16'h6080, 16'h2480, 16'hF080});
        rd(bod_pkg::REG_STATE);
        chk("skip", d & M, 32'h3B0003A2);
        $display("skip test done");
    endtask
    // File-to-file move, then add from the access bank
    task automatic t_move();
        run('{16'hCF80, 16'hF000, 16'h2400});
        rd(bod_pkg::REG_STATE);
        chk("move", d & M, 32'h3B0010DE);
        $display("move test done");
    endtask
    // Bank select, indexed offset, multiply, prescaler clear on timer
    task automatic t_modes();
        wr(bod_pkg::REG_BANK, 32'h2);
        wr(bod_pkg::REG_INDEX, 32'h200);
        wr(bod_pkg::REG_CTRL, 32'h3);
        run('{16'hCF80, 16'hF210, 16'h2510, 16'h0210, 16'h6290});
        rd(bod_pkg::REG_STATE);
        chk("modes", d & M, 32'h3B00031A);
        rd(bod_pkg::REG_PROD);
        chk("product", d, 32'h0000_0618);
        $display("mode test done");
    endtask
    // Verdict
    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_arith();
        t_skip();
        t_move();
        t_modes();
        finish_test();
    end
endmodule
